// File: pkg/gecpg_pkg.sv
// Package of constants, types and register map for the gated event counter and pulse unit.
package gecpg_pkg;

  // Register byte addresses, one 32-bit word each, spaced four bytes apart.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_DELAY = 8'h08;
  localparam logic [7:0] ADDR_WIDTH = 8'h0C;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // Control register field positions.
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_EDGE_BIT = 1;
  localparam int CTRL_CASC_BIT = 2;
  localparam int CTRL_TB_BIT = 3;
  localparam int CTRL_POL_BIT = 4;
  localparam int CTRL_GATE_LSB = 8;

  // Command register field positions, self clearing.
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;

  // Values after reset.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] PHASE_RESET = 16'h0000;

  // Least phase length in timebase cycles when zero is requested on the internal timebase.
  localparam logic [15:0] MIN_PHASE_CYCLES = 16'h0003;

  // Gate modes.
  typedef enum logic [2:0] {
    GECPG_GATE_NONE = 3'h0,
    GECPG_GATE_HIGH = 3'h1,
    GECPG_GATE_LOW = 3'h2,
    GECPG_GATE_RISE_ONCE = 3'h3,
    GECPG_GATE_FALL_ONCE = 3'h4,
    GECPG_GATE_RISE_RETRIG = 3'h5,
    GECPG_GATE_FALL_RETRIG = 3'h6
  } gecpg_gate_t;

  // Configuration captured at start.
  typedef struct packed {
    gecpg_gate_t gate_mode;
    logic pol;
    logic timebase_ext;
    logic cascade;
    logic falling;
    logic pulse_mode;
    logic [15:0] delay;
    logic [15:0] width;
  } gecpg_cfg_t;

  // Register bus request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } gecpg_bus_t;

endpackage : gecpg_pkg

// File: verilog/gecpg_sync.sv
// Two-flop synchroniser with edge detection on the settled copy.
`timescale 1ns/1ps
module gecpg_sync
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous input and synchronised results.
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // First flop only feeds the second; edges are taken from the settled copies.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;

endmodule : gecpg_sync

// File: verilog/gecpg_top.sv
// Top of the gated event counter and single delayed pulse generator.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////////////
module gecpg_top
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  // External pins.
  input wire logic event_source_input,
  input wire logic gate_input,
  input wire logic ext_timebase_input,
  output logic pulse_output
);

  typedef enum logic [1:0] {
    GECPG_IDLE,
    GECPG_ARMED,
    GECPG_DELAY,
    GECPG_PULSE
  } gecpg_state_t;

  logic rst_meta_q;
  logic rst_n_q;
  logic [31:0] ctrl_q;
  logic [15:0] delay_q;
  logic [15:0] width_q;
  gecpg_pkg::gecpg_cfg_t cfg_q;
  gecpg_pkg::gecpg_bus_t bus;
  gecpg_state_t state_q;
  logic running_q;
  logic done_q;
  logic [15:0] cnt_lo_q;
  logic [15:0] cnt_hi_q;
  logic [15:0] phase_q;
  logic pulse_q;
  logic [31:0] rdata_q;
  logic src_rise, src_fall;
  logic gate_lvl, gate_rise, gate_fall;
  logic tb_lvl, tb_rise;
  logic start_cmd, stop_cmd;
  logic tick;
  logic gate_ok;
  logic trig, retrig;
  logic [15:0] delay_len, width_len;

  // Phase length; a zero request gives three cycles on the internal timebase and one on the external.
  function automatic logic [15:0] eff_len(input logic [15:0] req, input logic ext);
    if (req == 16'h0000 && !ext)
      return gecpg_pkg::MIN_PHASE_CYCLES;
    return (req == 16'h0000) ? 16'h0001 : req;
  endfunction : eff_len

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops so every flop leaves reset on the same edge.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Pin synchronisers.
  gecpg_sync u_src (.clk(clk), .rst_n(rst_n_q), .async_in(event_source_input),
    .level(), .rise(src_rise), .fall(src_fall));
  gecpg_sync u_gate (.clk(clk), .rst_n(rst_n_q), .async_in(gate_input),
    .level(gate_lvl), .rise(gate_rise), .fall(gate_fall));
  gecpg_sync u_tb (.clk(clk), .rst_n(rst_n_q), .async_in(ext_timebase_input),
    .level(tb_lvl), .rise(tb_rise), .fall());

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Register writes.
  assign bus = '{wr: wr_en, rd: rd_en, addr: addr, wdata: wdata};
  assign start_cmd = bus.wr && bus.addr == gecpg_pkg::ADDR_CMD
    && bus.wdata[gecpg_pkg::CMD_START_BIT];
  assign stop_cmd = bus.wr && bus.addr == gecpg_pkg::ADDR_CMD
    && bus.wdata[gecpg_pkg::CMD_STOP_BIT];

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ctrl_q <= gecpg_pkg::CTRL_RESET;
      delay_q <= gecpg_pkg::PHASE_RESET;
      width_q <= gecpg_pkg::PHASE_RESET;
    end
    else if (bus.wr)
    begin
      case (bus.addr)
        gecpg_pkg::ADDR_CTRL: ctrl_q <= bus.wdata;
        gecpg_pkg::ADDR_DELAY: delay_q <= bus.wdata[15:0];
        gecpg_pkg::ADDR_WIDTH: width_q <= bus.wdata[15:0];
        default: ;
      endcase
    end
  end

  // Start snapshots the configuration so later writes cannot disturb a running task.
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      cfg_q <= '0;
    else if (start_cmd)
    begin
      cfg_q.pulse_mode <= ctrl_q[gecpg_pkg::CTRL_MODE_BIT];
      cfg_q.falling <= ctrl_q[gecpg_pkg::CTRL_EDGE_BIT];
      cfg_q.cascade <= ctrl_q[gecpg_pkg::CTRL_CASC_BIT];
      cfg_q.timebase_ext <= ctrl_q[gecpg_pkg::CTRL_TB_BIT];
      cfg_q.pol <= ctrl_q[gecpg_pkg::CTRL_POL_BIT];
      cfg_q.gate_mode <= gecpg_pkg::gecpg_gate_t'(ctrl_q[gecpg_pkg::CTRL_GATE_LSB +: 3]);
      cfg_q.delay <= delay_q;
      cfg_q.width <= width_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Timebase tick and gate qualification.
  assign tick = cfg_q.timebase_ext ? tb_rise : 1'b1;
  assign delay_len = eff_len(cfg_q.delay, cfg_q.timebase_ext);
  assign width_len = eff_len(cfg_q.width, cfg_q.timebase_ext);

  always_comb
  begin
    gate_ok = 1'b1;
    trig = 1'b0;
    retrig = 1'b0;
    case (cfg_q.gate_mode)
      gecpg_pkg::GECPG_GATE_NONE: gate_ok = 1'b1;
      gecpg_pkg::GECPG_GATE_HIGH: gate_ok = gate_lvl;
      gecpg_pkg::GECPG_GATE_LOW: gate_ok = ~gate_lvl;
      gecpg_pkg::GECPG_GATE_RISE_ONCE: trig = gate_rise;
      gecpg_pkg::GECPG_GATE_FALL_ONCE: trig = gate_fall;
      gecpg_pkg::GECPG_GATE_RISE_RETRIG:
      begin
        trig = gate_rise;
        retrig = gate_rise;
      end
      gecpg_pkg::GECPG_GATE_FALL_RETRIG:
      begin
        trig = gate_fall;
        retrig = gate_fall;
      end
      default: gate_ok = 1'b0;
    endcase
  end

  // Running flag: start wins over a stop in the same write.
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      running_q <= 1'b0;
    else if (start_cmd)
      running_q <= 1'b1;
    else if (stop_cmd)
      running_q <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Event counters; the high half advances only on a cascaded carry.
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      cnt_lo_q <= 16'h0000;
      cnt_hi_q <= 16'h0000;
    end
    else if (start_cmd)
    begin
      cnt_lo_q <= 16'h0000;
      cnt_hi_q <= 16'h0000;
    end
    else if (running_q && !cfg_q.pulse_mode && gate_ok
      && (cfg_q.falling ? src_fall : src_rise))
    begin
      cnt_lo_q <= cnt_lo_q + 16'h0001;
      if (cfg_q.cascade && cnt_lo_q == 16'hFFFF)
        cnt_hi_q <= cnt_hi_q + 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Single-pulse sequencer; phase counter counts down timebase ticks.
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= GECPG_IDLE;
      phase_q <= 16'h0000;
      done_q <= 1'b0;
    end
    else if (start_cmd)
    begin
      done_q <= 1'b0;
      phase_q <= 16'h0000;
      state_q <= ctrl_q[gecpg_pkg::CTRL_MODE_BIT] ? GECPG_ARMED : GECPG_IDLE;
    end
    else if (stop_cmd)
      state_q <= GECPG_IDLE;
    else if (running_q && cfg_q.pulse_mode)
    begin
      case (state_q)
        GECPG_ARMED:
        begin
          if (cfg_q.gate_mode <= gecpg_pkg::GECPG_GATE_LOW || trig)
          begin
            state_q <= GECPG_DELAY;
            phase_q <= delay_len;
          end
        end
        GECPG_DELAY, GECPG_PULSE:
        begin
          if (retrig)
          begin
            state_q <= GECPG_DELAY;
            phase_q <= delay_len;
          end
          else if (tick && gate_ok)
          begin
            if (phase_q == 16'h0001)
            begin
              if (state_q == GECPG_DELAY)
              begin
                state_q <= GECPG_PULSE;
                phase_q <= width_len;
              end
              else
              begin
                state_q <= (cfg_q.gate_mode >= gecpg_pkg::GECPG_GATE_RISE_RETRIG)
                  ? GECPG_ARMED : GECPG_IDLE;
                done_q <= 1'b1;
              end
            end
            else
              phase_q <= phase_q - 16'h0001;
          end
        end
        default: ;
      endcase
    end
  end

  // Output level registered; only the pulse phase drives the pulse level.
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      pulse_q <= 1'b0;
    else
      pulse_q <= cfg_q.pol ^ (state_q == GECPG_PULSE);
  end
  assign pulse_output = pulse_q;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Read data, valid the cycle after the read strobe; unmapped reads return zero.
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      rdata_q <= 32'h0000_0000;
    else if (bus.rd)
    begin
      case (bus.addr)
        gecpg_pkg::ADDR_CTRL: rdata_q <= ctrl_q;
        gecpg_pkg::ADDR_DELAY: rdata_q <= {16'h0000, delay_q};
        gecpg_pkg::ADDR_WIDTH: rdata_q <= {16'h0000, width_q};
        gecpg_pkg::ADDR_COUNT: rdata_q <= {cnt_hi_q, cnt_lo_q};
        gecpg_pkg::ADDR_STATUS: rdata_q <= {27'h0, tb_lvl, done_q, state_q, running_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
    else
      rdata_q <= 32'h0000_0000;
  end
  assign rdata = rdata_q;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_q);

  count_edge_a: assert property (
    running_q && !cfg_q.pulse_mode && !start_cmd && gate_ok && !cfg_q.falling && src_rise
    |=> cnt_lo_q == $past(cnt_lo_q) + 16'h0001) else $error("Rising source edge not counted.");
  cascade_carry_a: assert property (
    $changed(cnt_hi_q) && !$past(start_cmd) |-> $past(cnt_lo_q) == 16'hFFFF && cfg_q.cascade)
    else $error("High counter moved without a carry.");
  start_clear_a: assert property (
    start_cmd |=> running_q && cnt_lo_q == 16'h0000 && cnt_hi_q == 16'h0000)
    else $error("Start did not clear and run.");
  // A fresh start after the stop legally clears the count, so that edge is excused.
  stop_hold_a: assert property (
    stop_cmd && !start_cmd |=> !running_q
    ##1 ($stable(cnt_lo_q) || $past(start_cmd)) [*3]) else $error("Counter moved after stop.");
  delay_level_a: assert property (
    state_q == GECPG_DELAY |=> pulse_output == cfg_q.pol) else $error("Delay phase level wrong.");
  pulse_level_a: assert property (
    state_q == GECPG_PULSE |=> pulse_output == !cfg_q.pol) else $error("Pulse phase level wrong.");
  min_delay_a: assert property (
    $rose(state_q == GECPG_DELAY) && !cfg_q.timebase_ext && cfg_q.delay == 16'h0000
    |-> phase_q == gecpg_pkg::MIN_PHASE_CYCLES) else $error("Zero delay not floored at three.");
  gate_high_a: assert property (
    cfg_q.gate_mode == gecpg_pkg::GECPG_GATE_HIGH && !gate_lvl && !start_cmd
    |=> $stable(cnt_lo_q)) else $error("Counted while gate low in mode one.");
  pulse_seen_c: cover property (state_q == GECPG_DELAY ##[1:20] state_q == GECPG_PULSE);
  carry_seen_c: cover property ($changed(cnt_hi_q));
  retrig_seen_c: cover property (retrig && state_q == GECPG_PULSE);

endmodule : gecpg_top

// File: tb/gecpg_pins_model.sv
// Model of the external TTL source, gate and timebase pins.
`timescale 1ns/1ps
module gecpg_pins_model
(
  // Pins toward the counter unit.
  output logic src,
  output logic gate,
  output logic ext_tb
);
  //////////////////////////////////////////////////////////////////////////////
  // Pins start low; each change lands 1 ns after the call; source and gate levels are held 8 clock periods, timebase levels 4.
  initial
  begin
    src = 1'b0;
    gate = 1'b0;
    ext_tb = 1'b0;
  end

  // Drive the event pin and hold the level.
  task automatic set_src(input logic v);
    #1;
    src = v;
    #39;
  endtask : set_src

  // Drive the gate pin and hold the level.
  task automatic set_gate(input logic v);
    #1;
    gate = v;
    #39;
  endtask : set_gate

  // Send n whole timebase periods of 8 clock cycles each.
  task automatic ticks(input int n);
    #1;
    repeat (n)
    begin
      ext_tb = 1'b1;
      #20;
      ext_tb = 1'b0;
      #20;
    end
  endtask : ticks
endmodule : gecpg_pins_model

// File: tb/testbench.sv
// Self-checking bench for the gated event counter and pulse unit.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic reset_n;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [31:0] rdata;
  logic src;
  logic gate;
  logic ext_tb;
  logic pulse_output;
  logic out_q = 1'b0;
  logic lvl;
  logic [31:0] d;
  int fail_count;
  int num_checks;
  int rises = 0;
  int min_len = int'(gecpg_pkg::MIN_PHASE_CYCLES);
  int r0;
  int dl;
  int wd;
  int dv[3] = '{0, 4, 1};
  int wv[3] = '{0, 2, 5};

  gecpg_top DUT (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .event_source_input(src), .gate_input(gate),
    .ext_timebase_input(ext_tb), .pulse_output(pulse_output));
  gecpg_pins_model pins (.src(src), .gate(gate), .ext_tb(ext_tb));

  //////////////////////////////////////////////////////////////////////////////
  // Clock, 5 ns period.
  always #2.5 clk = ~clk;

  // Counts high-going pulses, so scenarios can see how many appeared.
  always @(posedge clk)
  begin
    out_q <= pulse_output;
    if (pulse_output === 1'b1 && out_q === 1'b0)
      rises <= rises + 1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One-cycle write strobe set on an edge; an edge always passes between two strobes.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr

  // One-cycle read strobe; data stand only in the following cycle.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    v = rdata;
  endtask : rd

  task automatic chk_reg(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", s, e, g);
      fail_count++;
    end
  endtask : chk_reg

  task automatic chk_num(input string s, input int e, input int g);
    num_checks++;
    if (g != e)
    begin
      $display("mismatch %s expected %0d seen %0d", s, e, g);
      fail_count++;
    end
  endtask : chk_num

  // Times delay and pulse phases in cycles, counted from the start edge.
  task automatic measure(input logic pol);
    dl = 0;
    wd = 0;
    while (pulse_output !== pol && dl < 900)
    begin
      @(posedge clk);
      #1;
      dl++;
    end
    while (pulse_output === pol && dl < 900)
    begin
      @(posedge clk);
      #1;
      dl++;
    end
    while (pulse_output === ~pol && wd < 900)
    begin
      @(posedge clk);
      #1;
      wd++;
    end
  endtask : measure

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  // Watchdog: the tests need well under 20000 cycles.
  initial
  begin
    #100000;
    fail_count++;
    end_sim();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    reset_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    fail_count = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(gecpg_pkg::ADDR_CTRL, d);
    chk_reg("ctrl reset", gecpg_pkg::CTRL_RESET, d);
    rd(8'h20, d);
    chk_reg("unmapped", 32'h0000_0000, d);
    // Rising edges counted, falls not; then falling edges after a restart.
    wr(gecpg_pkg::ADDR_CMD, 32'h0000_0001);
    pins.set_src(1'b1);
    rd(gecpg_pkg::ADDR_COUNT, d);
    chk_reg("count rise", 32'h0000_0001, d);
    pins.set_src(1'b0);
    rd(gecpg_pkg::ADDR_COUNT, d);
    chk_reg("count rise", 32'h0000_0001, d);
    wr(gecpg_pkg::ADDR_CTRL, 32'h0000_0002);
    wr(gecpg_pkg::ADDR_CMD, 32'h0000_0001);
    rd(gecpg_pkg::ADDR_COUNT, d);
    chk_reg("count restart", 32'h0000_0000, d);
    pins.set_src(1'b1);
    pins.set_src(1'b0);
    rd(gecpg_pkg::ADDR_COUNT, d);
    chk_reg("count fall", 32'h0000_0001, d);
    // A stopped counter holds its value.
    wr(gecpg_pkg::ADDR_CMD, 32'h0000_0002);
    pins.set_src(1'b1);
    pins.set_src(1'b0);
    rd(gecpg_pkg::ADDR_COUNT, d);
    chk_reg("count stop", 32'h0000_0001, d);
    // Level gating, cascaded: blocked level first, then the passing level.
    for (int g = 1; g < 3; g++)
    begin
      lvl = (g == 2);
      pins.set_gate(lvl);
      wr(gecpg_pkg::ADDR_CTRL, {21'h0, 3'(g), 8'h04});
      wr(gecpg_pkg::ADDR_CMD, 32'h0000_0001);
      pins.set_src(1'b1);
      pins.set_src(1'b0);
      pins.set_gate(~lvl);
      pins.set_src(1'b1);
      pins.set_src(1'b0);
      rd(gecpg_pkg::ADDR_COUNT, d);
      chk_reg("gated count", 32'h0000_0001, d);
    end
    // Single pulses; zero lengths fall back to three cycles.
    for (int i = 0; i < 3; i++)
    begin
      lvl = (i == 2);
      wr(gecpg_pkg::ADDR_DELAY, 32'(dv[i]));
      wr(gecpg_pkg::ADDR_WIDTH, 32'(wv[i]));
      wr(gecpg_pkg::ADDR_CTRL, {27'h0, lvl, 4'h1});
      wr(gecpg_pkg::ADDR_CMD, 32'h0000_0001);
      measure(lvl);
      chk_num("delay", (dv[i] == 0 ? min_len : dv[i]) + 2, dl);
      chk_num("width", (wv[i] == 0 ? min_len : wv[i]), wd);
      repeat (10) @(posedge clk);
      chk_reg("rest level", {31'h0, lvl}, {31'h0, pulse_output});
      rd(gecpg_pkg::ADDR_STATUS, d);
      chk_reg("done", 32'h0000_0009, d);
    end
    // External timebase: no pulse appears without ticks.
    wr(gecpg_pkg::ADDR_DELAY, 32'h0000_0002);
    wr(gecpg_pkg::ADDR_WIDTH, 32'h0000_0003);
    wr(gecpg_pkg::ADDR_CTRL, 32'h0000_0009);
    wr(gecpg_pkg::ADDR_CMD, 32'h0000_0001);
    r0 = rises;
    repeat (40) @(posedge clk);
    chk_num("no ticks", r0, rises);
    fork
      pins.ticks(12);
      measure(1'b0);
    join
    chk_num("ext width", 3, (wd + 4) / 8);
    // Edge-started modes: one pulse for 3 and 4, one per edge for 5 and 6.
    wr(gecpg_pkg::ADDR_WIDTH, 32'h0000_0002);
    for (int m = 3; m < 7; m++)
    begin
      lvl = (m == 4 || m == 6);
      pins.set_gate(lvl);
      wr(gecpg_pkg::ADDR_CTRL, {21'h0, 3'(m), 8'h01});
      wr(gecpg_pkg::ADDR_CMD, 32'h0000_0001);
      r0 = rises;
      repeat (20) @(posedge clk);
      chk_num("armed", r0, rises);
      for (int k = 1; k < 3; k++)
      begin
        pins.set_gate(~lvl);
        pins.set_gate(lvl);
        repeat (20) @(posedge clk);
        chk_num("edge pulses", r0 + ((m > 4) ? k : 1), rises);
      end
    end
    end_sim();
  end
endmodule : testbench
